// File: bench/i2c_host_model.sv
// Local I2C host model: START, address byte, STOP on open-drain lines
`timescale 1ns/10ps
module i2c_host_model (
    input  wire logic osc_clk,
    output logic      scl_lo,
    output logic      sda_lo
);
    // Idle bus: both lines left to the pull-ups
    initial begin
        scl_lo = 1'b0;
        sda_lo = 1'b0;
    end
    // Whole oscillator periods, then step off the edge
    task automatic wosc(input int n);
        repeat (n) @(posedge osc_clk);
        #2;
    endtask
    // Data moves only while SCL is low, well clear of hold and filter
    task automatic send_addr(input logic [7:0] a);
        sda_lo = 1'b1;
        wosc(12);
        for (int i = 7; i >= 0; i--) begin
            scl_lo = 1'b1;
            wosc(4);
            sda_lo = ~a[i];
            wosc(12);
            scl_lo = 1'b0;
            wosc(12);
        end
        scl_lo = 1'b1;
        sda_lo = 1'b1;
        wosc(12);
        scl_lo = 1'b0;
        wosc(12);
        sda_lo = 1'b0;
        wosc(12);
    endtask
endmodule

// File: bench/test_i2c_channel_timing_filter.sv
// Self-checking bench for the channel timing and filter block
`timescale 1ns/10ps
`include "i2c_timing_defs.svh"
module test_i2c_channel_timing_filter;
    import i2c_timing_pkg::*;
    logic       clk, rst, osc_clk, reg_wr, reg_rd, master_en;
    logic       stretch_go, stretch_bit, scl_out, scl_oe, sda_out;
    logic       sda_oe, fwd_valid, fwd_hit, h_scl_lo, h_sda_lo;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, ctl, pick;
    logic [6:0] own_id, deser_id, remote_id, fwd_id, id;
    logic [31:0] seed;
    mst_state_t mst_state;
    int         errors, comparisons, cycles, nvalid;
    // Open-drain wires with pull-ups
    wire logic  scl_in = ~(scl_oe | h_scl_lo);
    wire logic  sda_in = ~(sda_oe | h_sda_lo);

    i2c_channel_timing_filter u_i2c_channel_timing_filter (.*);
    i2c_host_model u_i2c_host_model (.osc_clk(osc_clk),
        .scl_lo(h_scl_lo), .sda_lo(h_sda_lo));

    // ************
    // Clocks, watchdog, forward monitor
    // ************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        osc_clk = 1'b0;
        #4;
        forever begin
            osc_clk = ~osc_clk;
            #40;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    always @(negedge osc_clk) if (fwd_valid === 1'b1) nvalid++;

    // ************
    // Helpers
    // ************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic exp_hit(input logic p, input logic [6:0] i);
        return p ? (i != own_id) : (i == deser_id || i == remote_id);
    endfunction
    task automatic check(input logic [15:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected t=%0t %s got %h exp %h",
                     $time, m, got, exp);
        end
    endtask
    task automatic wosc(input int n);
        repeat (n) @(posedge osc_clk);
        #2;
    endtask
    task automatic reg_write(input logic [7:0] a, d);
        @(posedge clk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #2;
        reg_wr = 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge clk);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #2;
        reg_rd = 1'b0;
        rd = reg_rdata;
    endtask
    // Address phase with a given control byte; flip changes it mid-byte
    task automatic fwd_case(input logic [6:0] i, input logic [7:0] c,
                            input logic flip);
        int v;
        reg_write(`REG_CTRL, c);
        wosc(12);
        v = nvalid;
        fork
            u_i2c_host_model.send_addr({i, i[0]});
            if (flip) begin
                wosc(60);
                reg_write(`REG_CTRL, c ^ 8'h80);
            end
        join
        check(16'(nvalid - v), 16'd1, "valid pulses");
        check(fwd_id, i, "captured id");
        check(fwd_hit, exp_hit(c[7], i), "forward");
    endtask
    task automatic run_master(input logic [7:0] lo, hi);
        int n;
        reg_write(`REG_LOW, lo);
        reg_write(`REG_HIGH, hi);
        wosc(12);
        master_en = 1'b1;
        wosc(1);
        check(mst_state, M_LOW, "master start");
        n = 0;
        while (scl_oe === 1'b1 && n < 600) begin
            wosc(1);
            n++;
        end
        check(16'(n), 16'(lo) + 16'd5, "low width");
        n = 0;
        while (scl_oe === 1'b0 && n < 600) begin
            wosc(1);
            n++;
        end
        check(16'(n), 16'(hi) + 16'd5, "high width");
        master_en = 1'b0;
        n = 0;
        while (mst_state !== M_IDLE && n < 1200) begin
            wosc(1);
            n++;
        end
        check(mst_state, M_IDLE, "master stop");
    endtask
    task automatic run_stretch(input logic [7:0] lo, input logic b);
        int n;
        reg_write(`REG_LOW, lo);
        wosc(12);
        stretch_go = 1'b1;
        stretch_bit = b;
        wosc(1);
        stretch_go = 1'b0;
        check({15'h0, sda_oe}, {15'h0, ~b}, "stretch data");
        n = 0;
        while (scl_oe === 1'b1 && n < 600) begin
            wosc(1);
            n++;
        end
        check(16'(n), (lo == 0) ? 16'd1 : 16'(lo), "stretch");
        u_i2c_host_model.scl_lo = 1'b1;
        wosc(8);
        check(sda_oe, 1'b0, "stretch release");
        u_i2c_host_model.scl_lo = 1'b0;
        wosc(8);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ************
    // Main sequence
    // ************
    initial begin
        seed = 32'h38e9;
        {rst, reg_wr, reg_rd, master_en, stretch_go, stretch_bit} = 6'h20;
        {reg_addr, reg_wdata} = 16'h0;
        own_id = 7'h0c;
        deser_id = 7'h2c;
        remote_id = 7'h50;
        repeat (6) @(posedge clk);
        #2;
        rst = 1'b0;
        wosc(4);
        reg_read(`REG_CTRL);
        check(rd, `CTRL_RST, "ctrl reset");
        reg_read(`REG_HIGH);
        check(rd, `HIGH_RST, "high reset");
        reg_read(`REG_LOW);
        check(rd, `LOW_RST, "low reset");
        reg_write(8'h1a, 8'hff);
        reg_read(8'h1a);
        check(rd, `ZERO_BYTE, "unmapped");
        for (int k = 0; k < 3; k++) begin
            pick = 8'(xs());
            reg_write(`REG_CTRL + 8'(k), pick);
            reg_read(`REG_CTRL + 8'(k));
            check(rd, pick, "readback");
        end
        $display("test registers done");
        for (int k = 0; k < 12; k++) begin
            pick = 8'(xs());
            case (pick[1:0])
                2'h0: id = own_id;
                2'h1: id = deser_id;
                2'h2: id = remote_id;
                default: id = 7'(xs());
            endcase
            ctl = {k[0], 7'(xs())};
            fwd_case(id, ctl, k >= 10);
        end
        $display("test forwarding done");
        run_master(`LOW_RST, `HIGH_RST);
        run_master(8'h00, 8'h00);
        for (int k = 0; k < 2; k++) begin
            pick = 8'(xs());
            run_master({5'h0, pick[2:0]}, {5'h0, pick[6:4]});
            run_stretch({6'h0, pick[1:0]}, pick[7]);
        end
        run_stretch(8'h00, 1'b0);
        $display("test master and stretch done");
        print_verdict();
    end
endmodule

// File: hdl/i2c_channel_timing_filter.sv
// Control-channel I2C forwarding, SDA hold, glitch filter and SCL timing
// Operation
// - Pass bit 0: forward only IDs of deserializer or remote target.
// - Pass-all set: forward every access not addressed to own ID.
// - Delay internal SDA against SCL by hold field times 40 ns.
// - Reject SCL and SDA glitches up to filter field times 5 ns.
// - As master, release SCL high for high count plus five periods.
// - As master, drive SCL low for low count plus five periods.
// - One count of high or low time equals one oscillator period.
// - Reset counts give at least 5 us phases at fast oscillator.
`timescale 1ns/10ps
`include "i2c_timing_defs.svh"
module i2c_channel_timing_filter (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    input  wire logic                  osc_clk,
    input  wire logic [6:0]            own_id,
    input  wire logic [6:0]            deser_id,
    input  wire logic [6:0]            remote_id,
    input  wire logic                  master_en,
    input  wire logic                  stretch_go,
    input  wire logic                  stretch_bit,
    input  wire logic                  scl_in,
    output logic                       scl_out,
    output logic                       scl_oe,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    output logic                       fwd_valid,
    output logic                       fwd_hit,
    output logic [6:0]                 fwd_id,
    output i2c_timing_pkg::mst_state_t mst_state
);
    import i2c_timing_pkg::*;

    clk_state_t c;
    clk_state_t next_c;
    osc_state_t q;
    osc_state_t next_q;
    logic       osc_rst;
    logic [3:0] filt_cyc;
    logic [2:0] hold_cyc;
    logic [7:0] taps;
    logic       sda_held;
    logic       scl_f;
    logic       cfg_ok;

    // ************************************************************
    // Register side on clk
    // ************************************************************

    // Register writes, reads and shadow push toward the link side
    always_comb begin
        next_c = c;
        next_c.ack_s = {c.ack_s[0], q.ack};
        if (c.pend && (c.req == c.ack_s[1])) begin
            next_c.sh_ctrl = c.ctrl;
            next_c.sh_high = c.high;
            next_c.sh_low = c.low;
            next_c.req = ~c.req;
            next_c.pend = 1'b0;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                `REG_CTRL: next_c.ctrl = reg_wdata;
                `REG_HIGH: next_c.high = reg_wdata;
                `REG_LOW:  next_c.low = reg_wdata;
                default: ;
            endcase
            next_c.pend = 1'b1;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `REG_CTRL: next_c.rdata = c.ctrl;
                `REG_HIGH: next_c.rdata = c.high;
                `REG_LOW:  next_c.rdata = c.low;
                default:   next_c.rdata = `ZERO_BYTE;
            endcase
        end
    end

    // Register update with reset values
    always_ff @(posedge clk) begin
        if (rst) begin
            c <= '0;
            c.ctrl <= `CTRL_RST;
            c.high <= `HIGH_RST;
            c.low <= `LOW_RST;
            c.sh_ctrl <= `CTRL_RST;
            c.sh_high <= `HIGH_RST;
            c.sh_low <= `LOW_RST;
        end else begin
            c <= next_c;
        end
    end

    assign reg_rdata = c.rdata;

    // ************************************************************
    // Link side on osc_clk
    // ************************************************************

    // Reset brought over to the oscillator domain
    assign osc_rst = q.rst_s[1];

    // Filter depth in cycles rounds up, hold in whole cycles
    assign filt_cyc = 4'((32'(q.ctrl[`FILT_MSB:`FILT_LSB]) * `FILT_STEP_NS
                      + `OSC_PERIOD_NS - 1) / `OSC_PERIOD_NS);
    assign hold_cyc = 3'(32'(q.ctrl[`HOLD_MSB:`HOLD_LSB]) * `HOLD_STEP_NS
                      / `OSC_PERIOD_NS);
    assign taps = {q.dly, q.filt[1]};
    assign sda_held = taps[hold_cyc];
    assign scl_f = q.filt[0];
    // Idle bus and idle clock engine, so no running phase changes length
    assign cfg_ok = !q.in_xfer && (q.st == M_IDLE);

    // Filter, address decode, config load and master clock
    always_comb begin
        next_q = q;
        next_q.rst_s = {q.rst_s[0], rst};
        next_q.pin_s1 = {sda_in, scl_in};
        next_q.pin_s2 = q.pin_s1;
        next_q.req_s = {q.req_s[0], c.req};
        next_q.fwd_v = 1'b0;
        // Glitch filter per line
        for (int i = 0; i < 2; i++) begin
            if (q.pin_s2[i] == q.filt[i]) begin
                next_q.fcnt[i] = 4'h0;
            end else if (q.fcnt[i] >= filt_cyc) begin
                next_q.filt[i] = q.pin_s2[i];
                next_q.fcnt[i] = 4'h0;
            end else begin
                next_q.fcnt[i] = q.fcnt[i] + 4'h1;
            end
        end
        next_q.dly = {q.dly[5:0], q.filt[1]};
        next_q.scl_d = scl_f;
        next_q.sda_d = sda_held;
        // Start, stop and first byte decode
        if (scl_f && q.scl_d && q.sda_d && !sda_held) begin
            next_q.in_xfer = 1'b1;
            next_q.bitn = 4'h0;
        end else if (scl_f && q.scl_d && !q.sda_d && sda_held) begin
            next_q.in_xfer = 1'b0;
        end else if (q.in_xfer && scl_f && !q.scl_d
                     && (q.bitn < `ADDR_BITS)) begin
            next_q.shift = {q.shift[6:0], sda_held};
            next_q.bitn = q.bitn + 4'h1;
        end
        // Eighth rise carries the R/W bit, the ID is the seven before it
        if (q.in_xfer && scl_f && !q.scl_d
            && (q.bitn == `ADDR_BITS - 4'h1)) begin
            next_q.fwd_v = 1'b1;
            next_q.fwd_id = q.shift[6:0];
            if (q.ctrl[`PASS_BIT]) begin
                next_q.fwd = (q.shift[6:0] != own_id);
            end else begin
                next_q.fwd = (q.shift[6:0] == deser_id)
                          || (q.shift[6:0] == remote_id);
            end
        end
        // Config taken only while no transfer runs
        if ((q.req_s[1] != q.ack) && cfg_ok) begin
            next_q.ctrl = c.sh_ctrl;
            next_q.high = c.sh_high;
            next_q.low = c.sh_low;
            next_q.ack = q.req_s[1];
        end
        // Release target data once the host clocks it
        if (q.sda_lo && (q.st != M_STRETCH) && !scl_f && q.scl_d) begin
            next_q.sda_lo = 1'b0;
        end
        unique case (q.st)
            M_IDLE: begin
                if (stretch_go) begin
                    next_q.st = M_STRETCH;
                    next_q.scl_lo = 1'b1;
                    next_q.sda_lo = ~stretch_bit;
                    next_q.cnt = (q.low == `ZERO_BYTE) ? 9'h000
                               : 9'(q.low) - 9'h001;
                end else if (master_en) begin
                    next_q.st = M_LOW;
                    next_q.scl_lo = 1'b1;
                    next_q.cnt = 9'(q.low) + 9'(`SCL_EXTRA - 1);
                end
            end
            M_LOW: begin
                if (q.cnt != 9'h000) begin
                    next_q.cnt = q.cnt - 9'h001;
                end else begin
                    next_q.st = M_HIGH;
                    next_q.scl_lo = 1'b0;
                    next_q.cnt = 9'(q.high) + 9'(`SCL_EXTRA - 1);
                end
            end
            M_HIGH: begin
                if (q.cnt != 9'h000) begin
                    next_q.cnt = q.cnt - 9'h001;
                end else if (master_en) begin
                    next_q.st = M_LOW;
                    next_q.scl_lo = 1'b1;
                    next_q.cnt = 9'(q.low) + 9'(`SCL_EXTRA - 1);
                end else begin
                    next_q.st = M_IDLE;
                end
            end
            M_STRETCH: begin
                if (q.cnt != 9'h000) begin
                    next_q.cnt = q.cnt - 9'h001;
                end else begin
                    next_q.st = M_IDLE;
                    next_q.scl_lo = 1'b0;
                end
            end
        endcase
    end

    // Link state register
    always_ff @(posedge osc_clk) begin
        if (osc_rst) begin
            q <= '0;
            q.rst_s <= next_q.rst_s; // Sync keeps sampling to leave reset
            q.pin_s1 <= 2'h3;
            q.pin_s2 <= 2'h3;
            q.filt <= 2'h3;
            q.dly <= 7'h7f;
            q.scl_d <= 1'b1;
            q.sda_d <= 1'b1;
            q.ctrl <= `CTRL_RST;
            q.high <= `HIGH_RST;
            q.low <= `LOW_RST;
            q.st <= M_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // Open-drain pins only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = q.scl_lo;
    assign sda_oe = q.sda_lo;
    assign fwd_valid = q.fwd_v;
    assign fwd_hit = q.fwd;
    assign fwd_id = q.fwd_id;
    assign mst_state = q.st;

    // ************************************************************
    // Checks
    // ************************************************************

    // Cycles spent in the present master state
    logic [9:0] ph;
    always_ff @(posedge osc_clk) begin
        if (osc_rst || (next_q.st != q.st)) begin
            ph <= 10'h000;
        end else begin
            ph <= ph + 10'h001;
        end
    end

    fwd_match_a: assert property (
        @(posedge osc_clk) disable iff (osc_rst)
        q.fwd_v && !q.ctrl[`PASS_BIT] |->
        q.fwd == ((q.fwd_id == deser_id) || (q.fwd_id == remote_id)))
        else $error("selective forward decision wrong");
    fwd_all_a: assert property (
        @(posedge osc_clk) disable iff (osc_rst)
        q.fwd_v && q.ctrl[`PASS_BIT] |-> q.fwd == (q.fwd_id != own_id))
        else $error("pass-all forward decision wrong");
    hold_one_a: assert property (
        @(posedge osc_clk) disable iff (osc_rst)
        (hold_cyc == 3'h1) && $past(hold_cyc == 3'h1) |->
        sda_held == $past(q.filt[1]))
        else $error("sda hold delay wrong");
    glitch_rej_a: assert property (
        @(posedge osc_clk) disable iff (osc_rst)
        $changed(q.filt[0]) |-> $past(q.fcnt[0]) >= $past(filt_cyc))
        else $error("scl glitch passed filter");
    high_width_a: assert property (
        @(posedge osc_clk) disable iff (osc_rst)
        (q.st == M_HIGH) && (q.cnt == 9'h000) |->
        ph + 10'h001 == 10'(q.high) + 10'(`SCL_EXTRA))
        else $error("scl high width wrong");
    low_width_a: assert property (
        @(posedge osc_clk) disable iff (osc_rst)
        (q.st == M_LOW) && (q.cnt == 9'h000) |->
        ph + 10'h001 == 10'(q.low) + 10'(`SCL_EXTRA))
        else $error("scl low width wrong");
    stretch_len_a: assert property (
        @(posedge osc_clk) disable iff (osc_rst)
        (q.st == M_STRETCH) && (q.cnt == 9'h000) && (q.low != `ZERO_BYTE)
        |-> ph + 10'h001 == 10'(q.low) ##1 !scl_oe)
        else $error("stretch length wrong");
    rst_val_a: assert property (
        @(posedge clk)
        $past(rst) && !rst |-> (c.high == `HIGH_RST) && (c.low == `LOW_RST))
        else $error("timing reset values wrong");
    cfg_stable_a: assert property (
        @(posedge osc_clk) disable iff (osc_rst)
        q.in_xfer && $past(q.in_xfer) |-> $stable(q.ctrl) && $stable(q.high))
        else $error("config changed inside transfer");

    fwd_cov_c: cover property (@(posedge osc_clk) q.fwd_v && q.fwd);
    master_cov_c: cover property (@(posedge osc_clk)
        (q.st == M_HIGH) ##1 (q.st == M_LOW));
    stretch_cov_c: cover property (@(posedge osc_clk)
        $fell(q.st == M_STRETCH));
endmodule

// File: hdl/i2c_timing_defs.svh
// Offsets, reset values, field positions and timing constants
`ifndef I2C_TIMING_DEFS_SVH
`define I2C_TIMING_DEFS_SVH
`define REG_CTRL      8'h17
`define REG_HIGH      8'h18
`define REG_LOW       8'h19
`define CTRL_RST      8'h1e
`define HIGH_RST      8'ha1
`define LOW_RST       8'ha5
`define ZERO_BYTE     8'h00
`define PASS_BIT      7
`define HOLD_MSB      6
`define HOLD_LSB      4
`define FILT_MSB      3
`define FILT_LSB      0
`define HOLD_STEP_NS  40
`define FILT_STEP_NS  5
`define OSC_PERIOD_NS 40
`define SCL_EXTRA     5
`define ADDR_BITS     4'h8
`endif

// File: hdl/i2c_timing_pkg.sv
// Types shared by the channel timing and filter block
package i2c_timing_pkg;
    typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH, M_STRETCH} mst_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] high;
        logic [7:0] low;
        logic [7:0] sh_ctrl;
        logic [7:0] sh_high;
        logic [7:0] sh_low;
        logic       req;
        logic [1:0] ack_s;
        logic       pend;
        logic [7:0] rdata;
    } clk_state_t;

    typedef struct packed {
        logic [1:0]      rst_s;
        logic [1:0]      pin_s1;
        logic [1:0]      pin_s2;
        logic [1:0]      filt;
        logic [1:0][3:0] fcnt;
        logic [6:0]      dly;
        logic            scl_d;
        logic            sda_d;
        logic            in_xfer;
        logic [3:0]      bitn;
        logic [7:0]      shift;
        logic            fwd;
        logic            fwd_v;
        logic [6:0]      fwd_id;
        logic [7:0]      ctrl;
        logic [7:0]      high;
        logic [7:0]      low;
        logic [1:0]      req_s;
        logic            ack;
        mst_state_t      st;
        logic [8:0]      cnt;
        logic            scl_lo;
        logic            sda_lo;
    } osc_state_t;
endpackage
